// ---- core/pin_routing_pkg.sv ----
package pin_routing_pkg;

  // Selection code layout
  localparam int SEL_W     = 5;
  localparam int PORT_W    = 2;
  localparam int PIN_W     = 3;
  localparam int PORT_LSB  = 3;
  localparam int PIN_COUNT = 8;

  // Port field codes
  localparam logic [1:0] PORT_FIRST    = 2'h0;
  localparam logic [1:0] PORT_SECOND   = 2'h1;
  localparam logic [1:0] PORT_THIRD    = 2'h2;
  localparam logic [1:0] PORT_RESERVED = 2'h3;

  // Register map, byte addresses
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] LOCK_OFFSET      = 12'h000;
  localparam logic [11:0] PIN_LEVEL_OFFSET = 12'h004;
  localparam logic [11:0] SEL_BASE         = 12'h100;
  localparam logic [11:0] SEL_LIMIT        = 12'h180;
  localparam int          INDEX_W          = 5;

  // Lock value after reset and response codes
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write request into the selection store
  typedef struct packed {
    logic                 en;
    logic [INDEX_W-1:0]   index;
    logic [SEL_W-1:0]     data;
  } selWrite_type;

  // Read channel sequencing
  typedef enum logic [1:0] {
    RD_IDLE   = 2'b00,
    RD_FETCH  = 2'b01,
    RD_ANSWER = 2'b10
  } readState_type;

  // Power-on selection per peripheral: port cycles over three, pin over eight
  function automatic logic [SEL_W-1:0] defaultSel(input int unsigned idx);
    logic [1:0] port;
    logic [2:0] pin;
    port = 2'((idx / 8) % 3);
    pin  = 3'(idx % 8);
    return {port, pin};
  endfunction

endpackage

// ---- core/select_mem.sv ----
module select_mem #(
  parameter int NUM = 31
) (
  // Clock and power-on reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     reset,
  // Write and read access
  input  wire pin_routing_pkg::selWrite_type            wr,
  input  wire logic [pin_routing_pkg::INDEX_W-1:0]      rdIndex,
  output logic      [pin_routing_pkg::SEL_W-1:0]        rdData,
  // All selections for the routing logic
  output logic      [NUM*pin_routing_pkg::SEL_W-1:0]    selAll
);

  logic [pin_routing_pkg::SEL_W-1:0] sel_q [NUM];
  logic [pin_routing_pkg::SEL_W-1:0] rdData_q;

  // Selection store; only power-on reset reloads it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM; i++) begin
        sel_q[i] <= pin_routing_pkg::defaultSel(i);
      end
    end else if (wr.en && (int'(wr.index) < NUM)) begin
      sel_q[wr.index] <= wr.data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData_q <= 5'h00;
    end else if (int'(rdIndex) < NUM) begin
      rdData_q <= sel_q[rdIndex];
    end else begin
      rdData_q <= 5'h00;
    end
  end

  assign rdData = rdData_q;

  // Flatten for the router
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      selAll[i*pin_routing_pkg::SEL_W +: pin_routing_pkg::SEL_W] = sel_q[i];
    end
  end

endmodule

// ---- core/port_router.sv ----
module port_router #(
  parameter int NUM = 31
) (
  // Clock and reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     reset,
  // Pin levels of the three ports
  input  wire logic [7:0]                               firstIoPort,
  input  wire logic [7:0]                               secondIoPort,
  input  wire logic [7:0]                               thirdIoPort,
  // Selections and routed peripheral inputs
  input  wire logic [NUM*pin_routing_pkg::SEL_W-1:0]    selAll,
  output logic      [NUM-1:0]                           periphIn
);

  logic [NUM-1:0] periphIn_q;

  // One routed level for one selection code
  function automatic logic pickPin(input logic [4:0] sel, input logic [7:0] a,
                                   input logic [7:0] b, input logic [7:0] c);
    logic [2:0] pin;
    pin = sel[2:0];
    case (sel[4:3])
      pin_routing_pkg::PORT_FIRST:  pickPin = a[pin];
      pin_routing_pkg::PORT_SECOND: pickPin = b[pin];
      pin_routing_pkg::PORT_THIRD:  pickPin = c[pin];
      default:                      pickPin = 1'b0;    // Reserved code routes low
    endcase
  endfunction

  // Several peripherals may share one pin
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      periphIn_q <= '0;
    end else begin
      for (int i = 0; i < NUM; i++) begin
        periphIn_q[i] <= pickPin(selAll[i*5 +: 5], firstIoPort, secondIoPort,
                                 thirdIoPort);
      end
    end
  end

  assign periphIn = periphIn_q;

endmodule

// ---- core/pin_routing_unit.sv ----
// Functional notes
// - Sleep leaves all routing selections untouched.
// - Power-on reset loads default selections.
// - Other resets keep selections as held.
// - Selection bits seven to five read zero.
// - Bits four-three pick port; code three reserved.
// - Bits two-zero pick pin within port.
// - Each peripheral has its own power-on default.
// - Lock flag set blocks selection writes.
// - Shared pins allowed; port reads show levels.
module pin_routing_unit #(
  parameter int NUM = 31
) (
  // Clock and power-on reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  reset,
  // AXI4-Lite write address and data
  input  wire logic [pin_routing_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  input  wire logic [31:0]                           wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  // AXI4-Lite write response
  output logic [1:0]                                 bresp,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  // AXI4-Lite read
  input  wire logic [pin_routing_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  output logic [31:0]                                rdata,
  output logic [1:0]                                 rresp,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  // Device pins and routed peripheral inputs
  input  wire logic [7:0]                            firstIoPort,
  input  wire logic [7:0]                            secondIoPort,
  input  wire logic [7:0]                            thirdIoPort,
  output logic      [NUM-1:0]                        periphIn,
  output logic                                       routingLockFlag
);

  logic [pin_routing_pkg::ADDR_W-1:0]  awaddr_q;
  logic [31:0]                         wdata_q;
  logic [3:0]                          wstrb_q;
  logic                                awHeld_q;
  logic                                wHeld_q;
  logic                                awready_q;
  logic                                wready_q;
  logic                                bvalid_q;
  logic [1:0]                          bresp_q;
  logic                                lock_q;
  logic                                arready_q;
  logic                                rvalid_q;
  logic [31:0]                         rdata_q;
  logic [1:0]                          rresp_q;
  logic [pin_routing_pkg::ADDR_W-1:0]  araddr_q;
  pin_routing_pkg::readState_type      rdState_q;
  pin_routing_pkg::readState_type      rdState_d;
  logic                                awTake;
  logic                                wTake;
  logic                                arTake;
  logic                                doWrite;
  pin_routing_pkg::selWrite_type       selWrite;
  logic [pin_routing_pkg::SEL_W-1:0]   memRdData;
  logic [NUM*pin_routing_pkg::SEL_W-1:0] selAll;
  logic                                awHeld_d;
  logic                                wHeld_d;
  logic                                selHit;
  logic                                lockWrite;
  logic [1:0]                          wrResp;
  logic [23:0]                         pinWord;
  logic [31:0]                         rdMux;
  logic [1:0]                          rdResp;

  // Address falls on an implemented selection register
  function automatic logic isSel(input logic [11:0] addr);
    logic [11:0] off;
    logic        inRange;
    logic        aligned;
    off     = addr - pin_routing_pkg::SEL_BASE;
    inRange = (addr >= pin_routing_pkg::SEL_BASE) && (addr < pin_routing_pkg::SEL_LIMIT);
    aligned = (addr[1:0] == 2'h0);
    isSel   = inRange && aligned && (int'(off >> 2) < NUM);
  endfunction

  // Selection index of an address
  function automatic logic [4:0] selIndex(input logic [11:0] addr);
    logic [11:0] off;
    off = addr - pin_routing_pkg::SEL_BASE;
    selIndex = off[6:2];
  endfunction

  // Address has any register behind it
  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = isSel(addr) || (addr == pin_routing_pkg::LOCK_OFFSET)
               || (addr == pin_routing_pkg::PIN_LEVEL_OFFSET);
  endfunction

  // Handshake terms
  always_comb begin
    awTake  = awvalid && awready_q;
    wTake   = wvalid && wready_q;
    arTake  = arvalid && arready_q;
    doWrite = awHeld_q && wHeld_q && !bvalid_q;
    awHeld_d = awTake || (awHeld_q && !doWrite);
    wHeld_d  = wTake || (wHeld_q && !doWrite);
  end

  // Write decode of the held address; lock register itself is never locked
  always_comb begin
    selHit    = isSel(awaddr_q);
    lockWrite = doWrite && wstrb_q[0] && (awaddr_q == pin_routing_pkg::LOCK_OFFSET);
    if (isMapped(awaddr_q)) begin
      wrResp = pin_routing_pkg::RESP_OKAY;
    end else begin
      wrResp = pin_routing_pkg::RESP_SLVERR;
    end
  end

  // Write address holding
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awHeld_q  <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else begin
      if (awTake) begin
        awaddr_q <= awaddr;
      end
      awHeld_q  <= awHeld_d;
      awready_q <= !awHeld_d;
    end
  end

  // Write data holding
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wHeld_q  <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (wTake) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      wHeld_q  <= wHeld_d;
      wready_q <= !wHeld_d;
    end
  end

  // Write response
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pin_routing_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wrResp;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Lock flag; a write with bit zero low clears it in this block
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lock_q <= pin_routing_pkg::LOCK_RESET;
    end else if (lockWrite) begin
      lock_q <= wdata_q[0];
    end
  end

  // Selection write, dropped while locked; only low five bits stored
  always_comb begin
    selWrite.en    = doWrite && wstrb_q[0] && selHit && !lock_q;
    selWrite.index = selIndex(awaddr_q);
    selWrite.data  = wdata_q[pin_routing_pkg::SEL_W-1:0];
  end

  // Selection store: async reset is power-on only, no sleep input
  select_mem #(
    .NUM     (NUM)
  ) u_store (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wr      (selWrite),
    .rdIndex (selIndex(araddr)),
    .rdData  (memRdData),
    .selAll  (selAll)
  );

  // Routing takes the stored value at the edge after the write
  port_router #(
    .NUM          (NUM)
  ) u_router (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .firstIoPort  (firstIoPort),
    .secondIoPort (secondIoPort),
    .thirdIoPort  (thirdIoPort),
    .selAll       (selAll),
    .periphIn     (periphIn)
  );

  // Read sequencing
  always_comb begin
    rdState_d = rdState_q;
    case (rdState_q)
      pin_routing_pkg::RD_IDLE: begin
        if (arTake) begin
          rdState_d = pin_routing_pkg::RD_FETCH;
        end
      end
      pin_routing_pkg::RD_FETCH: begin
        rdState_d = pin_routing_pkg::RD_ANSWER;
      end
      pin_routing_pkg::RD_ANSWER: begin
        if (rready) begin
          rdState_d = pin_routing_pkg::RD_IDLE;
        end
      end
      default: begin
        rdState_d = pin_routing_pkg::RD_IDLE;
      end
    endcase
  end

  // Read state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdState_q <= pin_routing_pkg::RD_IDLE;
    end else begin
      rdState_q <= rdState_d;
    end
  end

  // Read handshake flags and address capture
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      araddr_q  <= 12'h000;
    end else begin
      arready_q <= (rdState_d == pin_routing_pkg::RD_IDLE);
      rvalid_q  <= (rdState_d == pin_routing_pkg::RD_ANSWER);
      if (arTake) begin
        araddr_q <= araddr;
      end
    end
  end

  // Pin levels as one word, third port on top
  assign pinWord = {thirdIoPort, secondIoPort, firstIoPort};

  // Read data select; upper selection bits read zero
  always_comb begin
    rdMux  = 32'h0000_0000;
    rdResp = pin_routing_pkg::RESP_OKAY;
    if (isSel(araddr_q)) begin
      rdMux = {27'h0000000, memRdData};
    end else if (araddr_q == pin_routing_pkg::LOCK_OFFSET) begin
      rdMux = {31'h00000000, lock_q};
    end else if (araddr_q == pin_routing_pkg::PIN_LEVEL_OFFSET) begin
      rdMux = {8'h00, pinWord};
    end else begin
      rdResp = pin_routing_pkg::RESP_SLVERR;
    end
  end

  // Read data register, loaded while fetching
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= pin_routing_pkg::RESP_OKAY;
    end else if (rdState_q == pin_routing_pkg::RD_FETCH) begin
      rdata_q <= rdMux;
      rresp_q <= rdResp;
    end
  end

  // Write channel outputs from flops
  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;

  // Read channel outputs from flops
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rdata           = rdata_q;
  assign rresp           = rresp_q;

  // Lock flag straight from its flop
  assign routingLockFlag = lock_q;

endmodule

// ---- testbench/pin_routing_unit_chk.sv ----
module pin_routing_unit_chk #(
  parameter int NUM = 31
) (
  // Clock and reset
  input wire logic           clk_sys,
  input wire logic           reset,
  // Write channels
  input wire logic [11:0]    awaddr,
  input wire logic           awvalid,
  input wire logic           awready,
  input wire logic [31:0]    wdata,
  input wire logic [3:0]     wstrb,
  input wire logic           wvalid,
  input wire logic           wready,
  input wire logic [1:0]     bresp,
  input wire logic           bvalid,
  input wire logic           bready,
  // Read channels
  input wire logic [11:0]    araddr,
  input wire logic           arvalid,
  input wire logic           arready,
  input wire logic [31:0]    rdata,
  input wire logic [1:0]     rresp,
  input wire logic           rvalid,
  input wire logic           rready,
  // Pins and routed inputs
  input wire logic [7:0]     firstIoPort,
  input wire logic [7:0]     secondIoPort,
  input wire logic [7:0]     thirdIoPort,
  input wire logic [NUM-1:0] periphIn,
  input wire logic           routingLockFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] wrAddr_q;
  logic [11:0] rdAddr_q;
  logic [4:0]  wrData_q;
  logic [4:0]  sel0_q;
  logic        wrStrb_q;
  logic        started_q;
  logic        bDone;
  logic        bPrev_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Register map decode
  function automatic logic mapped(input logic [11:0] a);
    return a == pin_routing_pkg::LOCK_OFFSET || a == pin_routing_pkg::PIN_LEVEL_OFFSET
      || (a >= pin_routing_pkg::SEL_BASE && a < pin_routing_pkg::SEL_BASE + 12'(4 * NUM));
  endfunction
  // Pin level picked by a code, reserved port gives low
  function automatic logic pick(input logic [4:0] s, input logic [23:0] p);
    return (s[4:3] == 2'h3) ? 1'b0 : p[s];
  endfunction
  assign bDone = bvalid && bready;
  // Captured requests and mirror of selection zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrAddr_q  <= 12'h000;
      rdAddr_q  <= 12'h000;
      wrData_q  <= 5'h00;
      wrStrb_q  <= 1'b0;
      sel0_q    <= 5'h00;  // Power-on code of peripheral zero
      started_q <= 1'b0;
      bPrev_q   <= 1'b0;
    end else begin
      started_q <= 1'b1;
      bPrev_q   <= bvalid;
      if (awvalid && awready) wrAddr_q <= awaddr;
      if (wvalid && wready) wrData_q <= wdata[4:0];
      if (wvalid && wready) wrStrb_q <= wstrb[0];
      if (arvalid && arready) rdAddr_q <= araddr;
      // Store updates at the edge that raises the response
      if (bvalid && !bPrev_q && wrAddr_q == pin_routing_pkg::SEL_BASE && wrStrb_q
          && !routingLockFlag)
        sel0_q <= wrData_q;
    end
  end
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not on time");
  a_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_read_answer:
    assert property (arvalid && arready |=> !arready ##1 rvalid)
    else $error("read data not on time");
  a_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_sel_upper_zero:
    assert property (rvalid && rdAddr_q >= pin_routing_pkg::SEL_BASE |-> rdata[31:5] == 27'h0)
    else $error("selection upper bits not zero");
  a_write_resp:
    assert property (bvalid |-> bresp == (mapped(wrAddr_q) ? 2'h0 : 2'h2))
    else $error("wrong write response code");
  a_lock_follow:
    assert property (bDone && wrAddr_q == pin_routing_pkg::LOCK_OFFSET && wrStrb_q
      |-> routingLockFlag == wrData_q[0])
    else $error("lock flag not written");
  a_route_zero:
    assert property (started_q
      |-> periphIn[0] == pick(sel0_q, $past({thirdIoPort, secondIoPort, firstIoPort})))
    else $error("peripheral zero misrouted");
  // Main scenarios reached
  c_locked_write: cover property (bDone && routingLockFlag && wrAddr_q == 12'h100);
  c_error_read: cover property (rvalid && rresp == 2'h2);
  c_reserved_port: cover property (started_q && sel0_q[4:3] == 2'h3);
endmodule

bind pin_routing_unit pin_routing_unit_chk #(.NUM(NUM)) chk_u (
  .clk_sys, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .firstIoPort, .secondIoPort, .thirdIoPort, .periphIn, .routingLockFlag
);

// ---- testbench/pin_source_model.sv ----
module pin_source_model (
  // Clock and control
  input wire logic        clk_sys,
  input wire logic        hold,
  input wire logic [23:0] pattern,
  // Pin levels
  output logic     [7:0]  firstIoPort,
  output logic     [7:0]  secondIoPort,
  output logic     [7:0]  thirdIoPort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] level_q = 24'h000000;
  // Pins follow the pattern when held, else walk every cycle
  always_ff @(posedge clk_sys) begin
    if (hold) level_q <= pattern;
    else level_q <= {level_q[22:0], ~level_q[23]};
  end
  assign {thirdIoPort, secondIoPort, firstIoPort} = level_q;
endmodule

// ---- testbench/peripheral_input_pin_select_bench.sv ----
module peripheral_input_pin_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          NUM  = 31;
  localparam logic [11:0] SEL0 = pin_routing_pkg::SEL_BASE;
  localparam logic [11:0] LOCK = pin_routing_pkg::LOCK_OFFSET;
  logic           clk_sys = 1'b0;
  logic           reset = 1'b1;
  logic [11:0]    awaddr = 12'h000;
  logic [11:0]    araddr = 12'h000;
  logic [31:0]    wdata = 32'h0;
  logic [3:0]     wstrb = 4'h0;
  logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic           hold = 1'b1;
  logic [23:0]    pinPattern = 24'h693CA5;
  logic           awready, wready, bvalid, arready, rvalid, routingLockFlag;
  logic [1:0]     bresp, rresp;
  logic [31:0]    rdata;
  logic [7:0]     firstIoPort, secondIoPort, thirdIoPort;
  logic [NUM-1:0] periphIn;
  int             n_mismatch = 0;
  int             compares = 0;
  // Far side and unit
  pin_source_model src_u (.clk_sys, .hold, .pattern(pinPattern),
                          .firstIoPort, .secondIoPort, .thirdIoPort);
  pin_routing_unit #(.NUM(NUM)) dut_u (
    .clk_sys, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .firstIoPort, .secondIoPort, .thirdIoPort, .periphIn, .routingLockFlag
  );
  // Clock
  initial forever #4 clk_sys = ~clk_sys;
  // Power-on code of peripheral i and the level it routes
  function automatic logic [31:0] defSel(input int i);
    return {27'h0, 2'(i / 8 % 3), 3'(i % 8)};
  endfunction
  function automatic logic [31:0] route(input logic [31:0] c);
    return (c[4:3] == 2'h3) ? 32'h0 : 32'(pinPattern[c[4:0]]);
  endfunction
  // Compare, verdict, bounded wait
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 64) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // Response channel: ready held high until the handshake edge
  task automatic answer(inout int n, input logic wr, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] seenData;
    logic [1:0]  seenResp;
    if (wr)
      bready <= 1'b1;
    else
      rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      tick(n);
    end while (!(wr ? bvalid : rvalid));
    seenData = rdata;
    seenResp = wr ? bresp : rresp;
    @(posedge clk_sys);
    bready <= 1'b0;
    rready <= 1'b0;
    if (!wr) check(seenData, ed);
    check(32'(seenResp), 32'(er));
  endtask
  task automatic busWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
    int n;
    logic aT, wT;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk_sys);
      aT = awvalid && awready;
      wT = wvalid && wready;
      @(posedge clk_sys);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      tick(n);
    end while ((awvalid && !aT) || (wvalid && !wT));
    answer(n, 1'b1, 32'h0, er);
  endtask
  task automatic busRead(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic aT;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk_sys);
      aT = arready;
      @(posedge clk_sys);
      tick(n);
    end while (!aT);
    arvalid <= 1'b0;
    answer(n, 1'b0, ed, er);
  endtask
  // Power-on selections, routing and lock state
  task automatic checkDefaults;
    @(negedge clk_sys);
    for (int i = 0; i < NUM; i++) check(32'(periphIn[i]), route(defSel(i)));
    for (int i = 0; i < NUM; i++) busRead(SEL0 + 12'(4 * i), defSel(i), 2'h0);
    busRead(LOCK, 32'h0, 2'h0);
  endtask
  // Every code on peripheral zero, upper bits written high
  task automatic routeAll;
    for (int c = 0; c < 32; c++) begin
      busWrite(SEL0, 32'hFFFFFFE0 | 32'(c), 4'h1, 2'h0);
      @(negedge clk_sys);
      check(32'(periphIn[0]), route(32'(c)));
      busRead(SEL0, 32'(c), 2'h0);
    end
  endtask
  // Two peripherals on one pin, pins read back
  task automatic sharedPin;
    busWrite(SEL0 + 12'h004, 32'h0D, 4'h1, 2'h0);
    busWrite(SEL0 + 12'h008, 32'h0D, 4'h1, 2'h0);
    @(negedge clk_sys);
    check(32'(periphIn[2:1]), {30'h0, {2{pinPattern[13]}}});
    busRead(pin_routing_pkg::PIN_LEVEL_OFFSET, {8'h00, pinPattern}, 2'h0);
  endtask
  // Lock blocks writes, strobe-less and unmapped accesses
  task automatic lockAndErrors;
    busWrite(LOCK, 32'h1, 4'h1, 2'h0);
    check(32'(routingLockFlag), 32'h1);
    busWrite(SEL0, 32'h0D, 4'h1, 2'h0);
    @(negedge clk_sys);
    check(32'(periphIn[0]), 32'h0);
    busRead(SEL0, 32'h1F, 2'h0);
    busWrite(LOCK, 32'h0, 4'h1, 2'h0);
    busWrite(SEL0, 32'h0D, 4'h1, 2'h0);
    @(negedge clk_sys);
    check(32'(periphIn[0]), route(32'h0D));
    busWrite(SEL0, 32'h00, 4'h0, 2'h0);
    busWrite(12'h200, 32'h1, 4'h1, 2'h2);
    busRead(12'h200, 32'h0, 2'h2);
  endtask
  // Idle with moving pins keeps selections, power-on reset restores them
  task automatic keepThenReset;
    hold <= 1'b0;
    repeat (40) @(posedge clk_sys);
    hold <= 1'b1;
    busRead(SEL0, 32'h0D, 2'h0);
    busWrite(LOCK, 32'h1, 4'h1, 2'h0);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    checkDefaults();
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    checkDefaults();
    routeAll();
    sharedPin();
    lockAndErrors();
    keepThenReset();
    wrap_up();
  end
endmodule
